/* File: wdg_counter.sv */
`timescale 1ns/1ns
`default_nettype none

package wdg_pkg;
  localparam logic [11:0] OFS_MODE     = 12'h000;
  localparam logic [11:0] OFS_ENABLE   = 12'h004;
  localparam logic [11:0] OFS_STATUS   = 12'h008;
  localparam logic [2:0]  MODE_FIXED   = 3'h3;
  localparam int          MODE_FIX_HI  = 7;
  localparam int          MODE_FIX_LO  = 5;
  localparam int          CS_HI_BIT    = 4;
  localparam int          CS_LO_BIT    = 3;
  localparam int          INTV_HI      = 2;
  localparam logic [7:0]  MODE_RESET   = 8'h67;
  localparam logic [7:0]  RESTART_CODE = 8'hAC;
  localparam logic [7:0]  ENABLE_READ  = 8'h9A;
  localparam int          INTV_BASE    = 10;
  localparam int          DIV_W        = 8;
  localparam logic [7:0]  DIV_FAST_MSK = 8'h0F;
  localparam logic [7:0]  DIV_SLOW_MSK = 8'hFF;

  typedef enum logic [2:0] {
    WDG_CAUSE_NONE,
    WDG_CAUSE_MODE_AGAIN,
    WDG_CAUSE_MODE_PARTIAL,
    WDG_CAUSE_BAD_CODE,
    WDG_CAUSE_BIT_OP,
    WDG_CAUSE_OVERFLOW
  } wdg_cause_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } wdg_apb_req_t;
endpackage

module wdg_counter #(
  parameter int CNT_W = 18
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       tick_i,
  input  wire logic       run_i,
  input  wire logic       restart_i,
  input  wire logic [2:0] sel_i,
  output logic            ovf_o,
  output logic [CNT_W-1:0] count_o
);
  import wdg_pkg::*;

  if (CNT_W < INTV_BASE + 8)
  begin : g_bad_cnt_w
    $error("wdg_counter: CNT_W too small for longest interval");
  end

  // ---------------------------------------------
  // counter and overflow
  // ---------------------------------------------
  wire logic [CNT_W-1:0] limit =
    CNT_W'((CNT_W+1)'(1) << (INTV_BASE + int'(sel_i))) - CNT_W'(1);
  wire logic hit = run_i && tick_i && (count_o == limit);

  always_ff @(posedge clk_i)
  begin
    if (reset_i || restart_i || !run_i || hit)
      count_o <= '0;
    else if (tick_i)
      count_o <= count_o + CNT_W'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      ovf_o <= 1'b0;
    else
      ovf_o <= hit && !restart_i;
  end
endmodule

`default_nettype wire

/* File: wdg_guard.sv */
// Operation
// - mode register accepts exactly one full-byte write after reset
// - any further mode write raises the internal reset
// - first write selecting stopped watchdog suppresses all misuse resets
// - mode register is never changed by a single-bit access
// - enable write other than restart code raises the internal reset
// - single-bit access to enable register raises the internal reset
// - enable register reads back a fixed byte unlike the restart code
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module wdg_guard #(
  parameter int CNT_W = 18
) (
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire wdg_pkg::wdg_apb_req_t apb_i,
  input  wire logic               bit_op_i,
  output logic                    pready_o,
  output logic                    pslverr_o,
  output logic [31:0]             prdata_o,
  output logic                    wdt_reset_o,
  output logic                    running_o
);
  import wdg_pkg::*;

  if (CNT_W < 18 || CNT_W > 30)
  begin : g_bad_cnt_w
    $error("wdg_guard: CNT_W out of range");
  end

  logic [7:0]       watchdog_mode;
  logic             mode_written;
  wdg_cause_t       cause;
  logic [DIV_W-1:0] div;
  logic             ovf;
  logic [CNT_W-1:0] count;

  // ---------------------------------------------
  // bus decode
  // ---------------------------------------------
  wire logic acc_first = apb_i.psel && apb_i.penable && !pready_o;
  wire logic acc_done  = apb_i.psel && apb_i.penable && pready_o;
  wire logic acc_wr    = acc_done && apb_i.pwrite;
  wire logic sel_mode  = apb_i.paddr == OFS_MODE;
  wire logic sel_en    = apb_i.paddr == OFS_ENABLE;
  wire logic sel_stat  = apb_i.paddr == OFS_STATUS;
  wire logic mapped    = sel_mode || sel_en || sel_stat;
  wire logic full_byte = apb_i.pstrb[0] && !bit_op_i;
  wire logic mode_wr   = acc_wr && sel_mode;
  wire logic en_wr     = acc_wr && sel_en;
  wire logic good_code = apb_i.pwdata[7:0] == RESTART_CODE;

  // ---------------------------------------------
  // misuse checks
  // ---------------------------------------------
  wire logic exempt = mode_written && watchdog_mode[CS_HI_BIT];
  wire logic mode_again   = mode_wr && mode_written;
  wire logic mode_partial = mode_wr && !mode_written
                            && !full_byte;
  wire logic en_bitop     = en_wr && !full_byte;
  wire logic en_badcode   = en_wr && full_byte && !good_code;
  wire logic restart      = en_wr && full_byte && good_code;
  wire logic run          = mode_written && !watchdog_mode[CS_HI_BIT];

  wire wdg_cause_t next_cause = wdg_cause_t'(
    exempt       ? WDG_CAUSE_NONE :
    mode_again   ? WDG_CAUSE_MODE_AGAIN :
    mode_partial ? WDG_CAUSE_MODE_PARTIAL :
    en_bitop     ? WDG_CAUSE_BIT_OP :
    en_badcode   ? WDG_CAUSE_BAD_CODE :
    ovf          ? WDG_CAUSE_OVERFLOW : WDG_CAUSE_NONE);
  wire logic next_rst = next_cause != WDG_CAUSE_NONE;

  // ---------------------------------------------
  // clock divider
  // ---------------------------------------------
  wire logic [DIV_W-1:0] div_msk =
    watchdog_mode[CS_LO_BIT] ? DIV_SLOW_MSK : DIV_FAST_MSK;
  wire logic tick = (div & div_msk) == '0;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      div <= '0;
    else
      div <= div + DIV_W'(1);
  end

  // ---------------------------------------------
  // mode register
  // ---------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      watchdog_mode <= MODE_RESET;
      mode_written  <= 1'b0;
    end
    else if (mode_wr && !mode_written && full_byte)
    begin
      watchdog_mode <= apb_i.pwdata[7:0];
      mode_written  <= 1'b1;
    end
  end

  // ---------------------------------------------
  // internal reset and cause
  // ---------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wdt_reset_o <= 1'b0;
      cause       <= WDG_CAUSE_NONE;
    end
    else
    begin
      wdt_reset_o <= next_rst;
      if (next_rst && cause == WDG_CAUSE_NONE)
        cause <= next_cause;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      running_o <= 1'b0;
    else
      running_o <= run;
  end

  wdg_counter #(
    .CNT_W (CNT_W)
  ) u_counter (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .tick_i    (tick),
    .run_i     (run),
    .restart_i (restart),
    .sel_i     (watchdog_mode[INTV_HI:0]),
    .ovf_o     (ovf),
    .count_o   (count)
  );

  // ---------------------------------------------
  // read path
  // ---------------------------------------------
  wire logic [31:0] rd_data =
    sel_mode ? {24'h0, watchdog_mode} :
    sel_en   ? {24'h0, ENABLE_READ} :
    sel_stat ? {27'h0, cause, running_o, mode_written} : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end
    else
    begin
      pready_o  <= acc_first;
      pslverr_o <= acc_first && !mapped;
      prdata_o  <= (acc_first && !apb_i.pwrite) ? rd_data : 32'h0;
    end
  end

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  AST_FIXED_BITS: assert property (
    mode_wr && !mode_written && full_byte |=>
      watchdog_mode[MODE_FIX_HI:MODE_FIX_LO] == $past(apb_i.pwdata[7:5]))
    else $error("mode fixed field not taken from write");
  AST_MODE_ONCE: assert property (
    mode_written |=> $stable(watchdog_mode) && mode_written)
    else $error("mode register changed after first write");
  AST_SECOND_WRITE: assert property (
    mode_wr && mode_written && !watchdog_mode[CS_HI_BIT] |=> wdt_reset_o)
    else $error("second mode write did not reset");
  AST_EXEMPT_QUIET: assert property (
    exempt ##1 exempt |-> !wdt_reset_o)
    else $error("reset raised while stopped exception holds");
  AST_PARTIAL_MODE: assert property (
    mode_wr && !mode_written && !full_byte |=>
      !mode_written && wdt_reset_o)
    else $error("partial mode write accepted");
  AST_BAD_CODE: assert property (
    en_wr && full_byte && !good_code && !exempt |=> wdt_reset_o)
    else $error("bad restart code did not reset");
  AST_BIT_OP_EN: assert property (
    en_wr && !full_byte && !exempt |=> wdt_reset_o ##1 !wdt_reset_o)
    else $error("bit access to enable did not reset once");
  AST_EN_READ: assert property (
    acc_first && sel_en && !apb_i.pwrite |=>
      pready_o && prdata_o == {24'h0, ENABLE_READ})
    else $error("enable read value wrong");
  AST_RESTART: assert property (
    restart |=> count == '0 && !ovf)
    else $error("restart did not clear counter");
  AST_OVERFLOW: assert property (
    ovf && !exempt |=> wdt_reset_o && cause != WDG_CAUSE_NONE)
    else $error("overflow did not reset");
endmodule

`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import wdg_pkg::*;
  logic         clk_i   = 1'b0;
  logic         reset_i = 1'b1;
  wdg_apb_req_t apb     = '0;
  logic         bit_op  = 1'b0;
  logic         pready, pslverr, wdt_rst, running;
  logic [31:0]  prdata;
  logic [31:0]  lfsr    = 32'h4E4A86F2;
  logic [31:0]  r;
  logic [7:0]   m_mode;
  logic [2:0]   m_cause;
  logic         m_wr, m_ex, e_rst;
  int           n_mismatch = 0;
  int           checked    = 0;
  int           k, i;

  wdg_guard #(.CNT_W(18)) uut (.clk_i(clk_i), .reset_i(reset_i),
    .apb_i(apb), .bit_op_i(bit_op), .pready_o(pready),
    .pslverr_o(pslverr), .prdata_o(prdata), .wdt_reset_o(wdt_rst),
    .running_o(running));

  always #5 clk_i = ~clk_i;

  // ---------------------------
  // helpers
  // ---------------------------
  task automatic end_sim();
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic do_reset();
    reset_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    m_mode = MODE_RESET;
    m_wr   = 1'b0;
    m_ex   = 1'b0;
    m_cause = WDG_CAUSE_NONE;
  endtask

  // apb access plus model of misuse detection
  task automatic acc(input logic wr, input logic [11:0] a,
                     input logic [7:0] d, input logic bo);
    logic [31:0] rd;
    logic        err;
    logic [2:0]  c;
    apb    <= '{1'b1, 1'b0, wr, a, {24'h0, d}, 4'hF};
    bit_op <= bo;
    @(posedge clk_i);
    apb.penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd  = prdata;
    err = pslverr;
    apb    <= '0;
    bit_op <= 1'b0;
    if (k >= 20)
    begin
      n_mismatch++;
      end_sim();
    end
    e_rst = 1'b0;
    c     = WDG_CAUSE_NONE;
    if (wr && !m_ex && a == OFS_ENABLE)
    begin
      e_rst = bo || d != RESTART_CODE;
      c     = bo ? WDG_CAUSE_BIT_OP : WDG_CAUSE_BAD_CODE;
    end
    if (wr && !m_ex && a == OFS_MODE)
    begin
      e_rst = m_wr || bo;
      c     = m_wr ? WDG_CAUSE_MODE_AGAIN : WDG_CAUSE_MODE_PARTIAL;
      if (!e_rst)
      begin
        m_mode = d;
        m_ex   = d[CS_HI_BIT];
        m_wr   = 1'b1;
      end
    end
    if (e_rst && m_cause == WDG_CAUSE_NONE)
      m_cause = c;
    chk(err, a > OFS_STATUS);
    if (!wr && a == OFS_MODE) chk(rd, m_mode);
    if (!wr && a == OFS_ENABLE) chk(rd, ENABLE_READ);
    if (!wr && a == OFS_STATUS)
      chk(rd, {27'h0, m_cause, m_wr && !m_ex, m_wr});
    @(posedge clk_i);
    chk(wdt_rst, e_rst);
    // running follows the stored mode one cycle later
    @(posedge clk_i);
    chk(running, m_wr && !m_ex);
  endtask

  // ---------------------------
  // main sequence
  // ---------------------------
  initial
  begin
    do_reset();
    acc(1'b0, OFS_ENABLE, 8'h00, 1'b0);
    acc(1'b0, 12'h00C, 8'h00, 1'b0);
    acc(1'b1, OFS_MODE, 8'h61, 1'b1);
    acc(1'b0, OFS_MODE, 8'h00, 1'b0);
    acc(1'b1, OFS_MODE, 8'h60, 1'b0);
    acc(1'b0, OFS_STATUS, 8'h00, 1'b0);
    r = rnd();
    acc(1'b1, OFS_MODE, {3'b011, r[4:0]}, 1'b0);
    acc(1'b0, OFS_MODE, 8'h00, 1'b0);
    acc(1'b1, OFS_ENABLE, RESTART_CODE, 1'b1);
    for (i = 0; i < 4; i++)
    begin
      r = rnd();
      acc(1'b1, OFS_ENABLE,
          r[7:0] ^ {7'h0, r[7:0] == RESTART_CODE}, 1'b0);
    end
    acc(1'b1, OFS_ENABLE, RESTART_CODE, 1'b0);
    repeat (10000) @(posedge clk_i);
    acc(1'b1, OFS_ENABLE, RESTART_CODE, 1'b0);
    k = 0;
    while (wdt_rst !== 1'b1 && k < 20000)
    begin
      @(posedge clk_i);
      k++;
    end
    chk(k >= (16 << INTV_BASE) - 15 && k <= (16 << INTV_BASE), 1'b1);
    do_reset();
    acc(1'b1, OFS_MODE, 8'h70, 1'b0);
    acc(1'b1, OFS_MODE, 8'h68, 1'b0);
    acc(1'b1, OFS_ENABLE, 8'h12, 1'b0);
    acc(1'b1, OFS_ENABLE, RESTART_CODE, 1'b1);
    acc(1'b0, OFS_MODE, 8'h00, 1'b0);
    acc(1'b0, OFS_STATUS, 8'h00, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
